// *** include/cts_regs.svh ***
`ifndef CTS_REGS_SVH
`define CTS_REGS_SVH
// ========================================
// register offsets (byte addresses)
`define CTS_CTRL_OFS       8'h00
`define CTS_STATUS_OFS     8'h04
`define CTS_TBLSEL_OFS     8'h08
`define CTS_COMB_OFS       8'h0C
`define CTS_OUT_OFS        8'h10
`define CTS_COND_BASE      8'h40
`define CTS_COND_LAST      8'h87
// ========================================
// field positions
`define CTS_CTRL_EN_BIT    0
`define CTS_TBL_W          4
`define CTS_COMB_W         3
`define CTS_COMB_STRIDE    4
`define CTS_A1_TYPE_LSB    0
`define CTS_A1_NUM_LSB     4
`define CTS_A2_TYPE_LSB    8
`define CTS_A2_NUM_LSB     12
`define CTS_OP_LSB         16
`define CTS_ST_SLOT_LSB    0
`define CTS_ST_VALID_BIT   2
`define CTS_ST_RES_LSB     8
// ========================================
// codes and reset values
`define CTS_SRC_UNUSED     4'h0
`define CTS_SRC_CONST      4'hF
`define CTS_OP_EQ          3'h0
`define CTS_OP_NE          3'h1
`define CTS_OP_GT          3'h2
`define CTS_OP_GE          3'h3
`define CTS_OP_LT          3'h4
`define CTS_OP_LE          3'h5
`define CTS_RES_FALSE      2'h0
`define CTS_RES_TRUE       2'h1
`define CTS_RES_ERR        2'h2
`define CTS_RES_NA         2'h3
`define CTS_COMB_DEFAULT   3'h0
`define CTS_COMB_AND3      3'h1
`define CTS_COMB_OR3       3'h2
`define CTS_COMB_AND_OR    3'h3
`define CTS_COMB_OR_AND    3'h4
`define CTS_TBL0_RST       4'h4
`define CTS_TBL1_RST       4'h5
`define CTS_TBL2_RST       4'h6
`endif

// *** include/cts_pkg.sv ***
// ========================================
// shared types
package cts_pkg;
    localparam int CTS_VAL_W = 16;

    typedef struct packed {
        logic [CTS_VAL_W-1:0] value;
        logic                 err;
        logic                 avail;
    } cts_src_t;

    typedef struct packed {
        logic [CTS_VAL_W-1:0] value;
        logic                 src_ok;
    } cts_tbl_t;

    typedef struct packed {
        logic [CTS_VAL_W-1:0] cval;
        logic [2:0]           op;
        logic [3:0]           a2_num;
        logic [3:0]           a2_type;
        logic [3:0]           a1_num;
        logic [3:0]           a1_type;
    } cts_cond_cfg_t;
endpackage : cts_pkg

// *** rtl/cts_selector.sv ***
`timescale 1ns/100ps
`include "cts_regs.svh"
module cts_selector
    import cts_pkg::*;
#(
    parameter int NUM_TYPES = 8,
    parameter int NUM_INST  = 8,
    parameter int NUM_TBL   = 16
)(
    input  wire logic                 mclk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [7:0]           paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  cts_src_t                  src_i [NUM_TYPES*NUM_INST],
    input  cts_tbl_t                  tbl_i [NUM_TBL],
    output logic      [CTS_VAL_W-1:0] out_value_o,
    output logic                      out_valid_o,
    output logic      [1:0]           out_slot_o
);
    // ========================================
    // register state
    logic                 enable;
    logic [3:0]           tbl_num [3];
    logic [2:0]           comb [3];
    cts_cond_cfg_t        cond_cfg [9];
    logic [1:0]           res [9];
    logic [2:0]           sel;
    logic [1:0]           act_slot;
    logic                 wr_en;
    logic                 acc;
    logic                 cond_hit;
    logic [3:0]           cond_idx;
    logic                 cond_is_const;
    logic                 mapped;
    logic [31:0]          rd_mux;
    logic [7:0]           cond_ofs;
    cts_tbl_t             act_tbl;

    // ========================================
    // apb slave: one wait state so read data can come from a flop
    assign acc      = psel_i && penable_i;
    assign wr_en    = acc && pwrite_i && pready_o;
    assign cond_ofs = paddr_i - `CTS_COND_BASE;
    assign cond_hit = (paddr_i >= `CTS_COND_BASE) && (paddr_i <= `CTS_COND_LAST)
                      && (paddr_i[1:0] == 2'h0);
    assign cond_idx = cond_ofs[6:3];
    assign cond_is_const = cond_ofs[2];
    assign mapped   = cond_hit || (paddr_i == `CTS_CTRL_OFS)
                      || (paddr_i == `CTS_STATUS_OFS) || (paddr_i == `CTS_TBLSEL_OFS)
                      || (paddr_i == `CTS_COMB_OFS) || (paddr_i == `CTS_OUT_OFS);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (cond_hit && cond_is_const)
        begin
            rd_mux[CTS_VAL_W-1:0] = cond_cfg[cond_idx].cval;
        end
        else if (cond_hit)
        begin
            rd_mux[`CTS_A1_TYPE_LSB +: 4] = cond_cfg[cond_idx].a1_type;
            rd_mux[`CTS_A1_NUM_LSB +: 4]  = cond_cfg[cond_idx].a1_num;
            rd_mux[`CTS_A2_TYPE_LSB +: 4] = cond_cfg[cond_idx].a2_type;
            rd_mux[`CTS_A2_NUM_LSB +: 4]  = cond_cfg[cond_idx].a2_num;
            rd_mux[`CTS_OP_LSB +: 3]      = cond_cfg[cond_idx].op;
        end
        else
        begin
            case (paddr_i)
                `CTS_CTRL_OFS:   rd_mux[`CTS_CTRL_EN_BIT] = enable;
                `CTS_STATUS_OFS:
                begin
                    rd_mux[`CTS_ST_SLOT_LSB +: 2] = out_slot_o;
                    rd_mux[`CTS_ST_VALID_BIT]     = out_valid_o;
                    for (int i = 0; i < 9; i++)
                    begin
                        rd_mux[`CTS_ST_RES_LSB + 2*i +: 2] = res[i];
                    end
                end
                `CTS_TBLSEL_OFS:
                begin
                    for (int s = 0; s < 3; s++)
                    begin
                        rd_mux[`CTS_TBL_W*s +: `CTS_TBL_W] = tbl_num[s];
                    end
                end
                `CTS_COMB_OFS:
                begin
                    for (int s = 0; s < 3; s++)
                    begin
                        rd_mux[`CTS_COMB_STRIDE*s +: `CTS_COMB_W] = comb[s];
                    end
                end
                `CTS_OUT_OFS:    rd_mux[CTS_VAL_W-1:0] = out_value_o;
                default:         rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o  <= acc && !pready_o;
            prdata_o  <= (acc && !pready_o && !pwrite_i) ? rd_mux : 32'h0000_0000;
            pslverr_o <= acc && !pready_o && !mapped;
        end
    end

    // ========================================
    // control registers
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            enable <= 1'b0;
        end
        else if (wr_en && paddr_i == `CTS_CTRL_OFS)
        begin
            enable <= pwdata_i[`CTS_CTRL_EN_BIT];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            tbl_num[0] <= `CTS_TBL0_RST;
            tbl_num[1] <= `CTS_TBL1_RST;
            tbl_num[2] <= `CTS_TBL2_RST;
            comb[0]    <= `CTS_COMB_AND3;
            comb[1]    <= `CTS_COMB_AND3;
            comb[2]    <= `CTS_COMB_DEFAULT;
        end
        else
        begin
            for (int s = 0; s < 3; s++)
            begin
                if (wr_en && paddr_i == `CTS_TBLSEL_OFS)
                begin
                    tbl_num[s] <= pwdata_i[`CTS_TBL_W*s +: `CTS_TBL_W];
                end
                if (wr_en && paddr_i == `CTS_COMB_OFS)
                begin
                    comb[s] <= pwdata_i[`CTS_COMB_STRIDE*s +: `CTS_COMB_W];
                end
            end
        end
    end

    // ========================================
    // condition configuration
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < 9; i++)
            begin
                cond_cfg[i].a1_type <= `CTS_SRC_UNUSED;
                cond_cfg[i].a2_type <= `CTS_SRC_UNUSED;
                cond_cfg[i].a1_num  <= 4'h0;
                cond_cfg[i].a2_num  <= 4'h0;
                cond_cfg[i].op      <= `CTS_OP_EQ;
                cond_cfg[i].cval    <= '0;
            end
        end
        else if (wr_en && cond_hit && cond_is_const)
        begin
            cond_cfg[cond_idx].cval <= pwdata_i[CTS_VAL_W-1:0];
        end
        else if (wr_en && cond_hit)
        begin
            cond_cfg[cond_idx].a1_type <= pwdata_i[`CTS_A1_TYPE_LSB +: 4];
            cond_cfg[cond_idx].a1_num  <= pwdata_i[`CTS_A1_NUM_LSB +: 4];
            cond_cfg[cond_idx].a2_type <= pwdata_i[`CTS_A2_TYPE_LSB +: 4];
            cond_cfg[cond_idx].a2_num  <= pwdata_i[`CTS_A2_NUM_LSB +: 4];
            // operator only moves when neither new source type is unused
            if (pwdata_i[`CTS_A1_TYPE_LSB +: 4] != `CTS_SRC_UNUSED
                && pwdata_i[`CTS_A2_TYPE_LSB +: 4] != `CTS_SRC_UNUSED)
            begin
                cond_cfg[cond_idx].op <= pwdata_i[`CTS_OP_LSB +: 3];
            end
        end
    end

    // ========================================
    // argument fetch and compare
    function automatic cts_src_t fetch(input logic [3:0] typ, input logic [3:0] num);
        cts_src_t r;
        int       idx;
        r   = '0;
        idx = (int'(typ) - 1) * NUM_INST + int'(num);
        // unused, constant or out-of-range selections read as unavailable
        if (typ != `CTS_SRC_UNUSED && int'(typ) <= NUM_TYPES && int'(num) < NUM_INST)
        begin
            r = src_i[idx];
        end
        return r;
    endfunction : fetch

    function automatic logic compare(input logic [2:0] op,
                                     input logic [CTS_VAL_W-1:0] a,
                                     input logic [CTS_VAL_W-1:0] b);
        logic r;
        case (op)
            `CTS_OP_EQ: r = (a == b);
            `CTS_OP_NE: r = (a != b);
            `CTS_OP_GT: r = (a > b);
            `CTS_OP_GE: r = (a >= b);
            `CTS_OP_LT: r = (a < b);
            `CTS_OP_LE: r = (a <= b);
            default:    r = 1'b0;
        endcase
        return r;
    endfunction : compare

    always_comb
    begin
        cts_src_t a1;
        cts_src_t a2;
        a1 = '0;
        a2 = '0;
        for (int i = 0; i < 9; i++)
        begin
            a1 = fetch(cond_cfg[i].a1_type, cond_cfg[i].a1_num);
            a2 = fetch(cond_cfg[i].a2_type, cond_cfg[i].a2_num);
            if (cond_cfg[i].a2_type == `CTS_SRC_CONST)
            begin
                a2 = '{value: cond_cfg[i].cval, err: 1'b0, avail: 1'b1};
            end
            // not applicable outranks error: a missing source cannot report one
            if (!a1.avail || !a2.avail)
            begin
                res[i] = `CTS_RES_NA;
            end
            else if (a1.err || a2.err)
            begin
                res[i] = `CTS_RES_ERR;
            end
            else
            begin
                res[i] = compare(cond_cfg[i].op, a1.value, a2.value) ?
                         `CTS_RES_TRUE : `CTS_RES_FALSE;
            end
        end
    end

    // ========================================
    // slot selection
    always_comb
    begin
        logic c1;
        logic c2;
        logic c3;
        logic n1;
        logic n2;
        logic n3;
        c1 = 1'b0;
        c2 = 1'b0;
        c3 = 1'b0;
        n1 = 1'b0;
        n2 = 1'b0;
        n3 = 1'b0;
        for (int s = 0; s < 3; s++)
        begin
            c1 = (res[3*s]   == `CTS_RES_TRUE);
            c2 = (res[3*s+1] == `CTS_RES_TRUE);
            c3 = (res[3*s+2] == `CTS_RES_TRUE);
            n1 = c1 || (res[3*s]   == `CTS_RES_NA);
            n2 = c2 || (res[3*s+1] == `CTS_RES_NA);
            n3 = c3 || (res[3*s+2] == `CTS_RES_NA);
            case (comb[s])
                `CTS_COMB_DEFAULT: sel[s] = 1'b1;
                `CTS_COMB_AND3:    sel[s] = n1 && n2 && n3;
                `CTS_COMB_OR3:     sel[s] = c1 || c2 || c3;
                `CTS_COMB_AND_OR:  sel[s] = (c1 && c2) || c3;
                `CTS_COMB_OR_AND:  sel[s] = (c1 || c2) && c3;
                default:           sel[s] = 1'b0;
            endcase
        end
    end

    // lowest selected slot wins, so a later default never overrides
    always_comb
    begin
        if (sel[0])
        begin
            act_slot = 2'h1;
        end
        else if (sel[1])
        begin
            act_slot = 2'h2;
        end
        else if (sel[2])
        begin
            act_slot = 2'h3;
        end
        else
        begin
            act_slot = 2'h0;
        end
    end

    always_comb
    begin
        act_tbl = '0;
        if (act_slot != 2'h0 && int'(tbl_num[act_slot - 2'h1]) < NUM_TBL)
        begin
            act_tbl = tbl_i[tbl_num[act_slot - 2'h1]];
        end
    end

    // ========================================
    // output register: one cycle behind the table
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            out_value_o <= '0;
            out_valid_o <= 1'b0;
            out_slot_o  <= 2'h0;
        end
        else if (!enable || act_slot == 2'h0)
        begin
            out_value_o <= '0;
            out_valid_o <= 1'b0;
            out_slot_o  <= enable ? act_slot : 2'h0;
        end
        else
        begin
            out_value_o <= act_tbl.src_ok ? act_tbl.value : '0;
            out_valid_o <= act_tbl.src_ok;
            out_slot_o  <= act_slot;
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    property p_reset_off;
        rst_b_i && !$past(rst_b_i) |-> !enable && !out_valid_o;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("enable set after reset");

    property p_disabled_na;
        !enable |=> !out_valid_o && out_value_o == '0;
    endproperty
    a_disabled_na: assert property (p_disabled_na) else $error("output valid while off");

    property p_pass;
        enable && act_slot != 2'h0 && act_tbl.src_ok
            |=> out_valid_o && out_value_o == $past(act_tbl.value);
    endproperty
    a_pass: assert property (p_pass) else $error("table value not passed through");

    property p_no_src;
        enable && act_slot != 2'h0 && !act_tbl.src_ok |=> !out_valid_o;
    endproperty
    a_no_src: assert property (p_no_src) else $error("unsourced table gave valid output");

    property p_order;
        sel[0] |-> act_slot == 2'h1;
    endproperty
    a_order: assert property (p_order) else $error("lower slot not preferred");

    property p_default;
        comb[1] == `CTS_COMB_DEFAULT && !sel[0] |-> act_slot == 2'h2;
    endproperty
    a_default: assert property (p_default) else $error("default slot not taken");

    property p_op_hold;
        wr_en && cond_hit && !cond_is_const && cond_idx == 4'h0
            && pwdata_i[`CTS_A1_TYPE_LSB +: 4] == `CTS_SRC_UNUSED |=> $stable(cond_cfg[0].op);
    endproperty
    a_op_hold: assert property (p_op_hold) else $error("operator changed without sources");

    property p_unused_na;
        cond_cfg[0].a1_type == `CTS_SRC_UNUSED |-> res[0] == `CTS_RES_NA;
    endproperty
    a_unused_na: assert property (p_unused_na) else $error("unused source not n/a");

    property p_and_na;
        comb[0] == `CTS_COMB_AND3 && res[0] == `CTS_RES_NA && res[1] == `CTS_RES_NA
            && res[2] == `CTS_RES_NA |-> sel[0];
    endproperty
    a_and_na: assert property (p_and_na) else $error("and3 rejected all n/a");

    property p_or_none;
        comb[0] == `CTS_COMB_OR3 && res[0] != `CTS_RES_TRUE && res[1] != `CTS_RES_TRUE
            && res[2] != `CTS_RES_TRUE |-> !sel[0];
    endproperty
    a_or_none: assert property (p_or_none) else $error("or3 selected without true");

    property p_apb_wait;
        acc && !pready_o |=> pready_o;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");
endmodule : cts_selector

// *** verification/cts_partner.sv ***
`timescale 1ns/100ps
// ========================================
// far side: argument sources and lookup table outputs
module cts_partner
    import cts_pkg::*;
#(
    parameter int NSRC = 4,
    parameter int NTBL = 16
)(
    output cts_src_t src_o [NSRC],
    output cts_tbl_t tbl_o [NTBL]
);
    // everything reads as unavailable until the first refresh
    initial
    begin
        foreach (src_o[i]) src_o[i] = '0;
        foreach (tbl_o[i]) tbl_o[i] = '0;
    end

    // values kept small so that equal and not-equal both occur often
    task automatic refresh(inout int s);
        foreach (src_o[i])
        begin
            src_o[i].value <= 16'($unsigned($random(s)) % 4);
            src_o[i].err   <= ($random(s) & 7) == 0;
            src_o[i].avail <= ($random(s) & 7) != 0;
        end
        foreach (tbl_o[i])
        begin
            tbl_o[i].value  <= 16'($random(s));
            tbl_o[i].src_ok <= ($random(s) & 3) != 0;
        end
    endtask : refresh
endmodule : cts_partner

// *** verification/cts_selector_bench.sv ***
`timescale 1ns/100ps
`include "cts_regs.svh"
module cts_selector_bench
    import cts_pkg::*;
;
    localparam int NT = 2;
    localparam int NI = 2;
    logic                 mclk;
    logic                 rst_b   = 1'b0;
    logic                 psel    = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite  = 1'b0;
    logic [7:0]           paddr   = 8'h00;
    logic [31:0]          pwdata  = 32'h0;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    cts_src_t             src [NT*NI];
    cts_tbl_t             tbl [16];
    logic [CTS_VAL_W-1:0] out_value;
    logic                 out_valid;
    logic [1:0]           out_slot;
    int                   num_errors = 0;
    int                   n_compared = 0;
    int                   seed = 17;
    int                   en = 0;
    int                   tsel [3] = '{4, 5, 6};
    int                   comb [3] = '{1, 1, 0};
    int                   a1t [9], a1n [9], a2t [9], a2n [9], op [9], cv [9];

    cts_selector #(.NUM_TYPES(NT), .NUM_INST(NI), .NUM_TBL(16)) DUT (
        .mclk_i(mclk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .src_i(src), .tbl_i(tbl),
        .out_value_o(out_value), .out_valid_o(out_valid), .out_slot_o(out_slot));
    cts_partner #(.NSRC(NT*NI), .NTBL(16)) far (.src_o(src), .tbl_o(tbl));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ========================================
    // checking and bus tasks
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // entered just after a rising edge; request held until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                       output logic [31:0] d, output logic e);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        chk("pready", 32'(pready), 32'h1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never reassigns psel in this step
        @(posedge mclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic        e;
        apb(1'b1, a, v, d, e);
    endtask : wr

    function automatic int rnd(int m);
        return $unsigned($random(seed)) % m;
    endfunction : rnd

    // ========================================
    // reference model
    function automatic int cres(int i);
        cts_src_t s1;
        cts_src_t s2;
        if (a1t[i] == 0 || a1t[i] == 15 || a2t[i] == 0)
            return 3;
        s1 = src[(a1t[i] - 1) * NI + a1n[i]];
        s2 = '{value: 16'(cv[i]), err: 1'b0, avail: 1'b1};
        if (a2t[i] != 15)
            s2 = src[(a2t[i] - 1) * NI + a2n[i]];
        if (!s1.avail || !s2.avail)
            return 3;
        if (s1.err || s2.err)
            return 2;
        case (op[i])
            0: return int'(s1.value == s2.value);
            1: return int'(s1.value != s2.value);
            2: return int'(s1.value > s2.value);
            3: return int'(s1.value >= s2.value);
            4: return int'(s1.value < s2.value);
            5: return int'(s1.value <= s2.value);
            default: return 0;
        endcase
    endfunction : cres

    function automatic bit pick(int s);
        int r [3];
        for (int k = 0; k < 3; k++)
            r[k] = cres(s * 3 + k);
        case (comb[s])
            0: return 1'b1;
            1: return r[0] % 2 && r[1] % 2 && r[2] % 2;
            2: return r[0] == 1 || r[1] == 1 || r[2] == 1;
            3: return (r[0] == 1 && r[1] == 1) || r[2] == 1;
            4: return (r[0] == 1 || r[1] == 1) && r[2] == 1;
            default: return 1'b0;
        endcase
    endfunction : pick

    task automatic check_all();
        int          s;
        int          vld;
        logic [15:0] ev;
        logic [31:0] st;
        logic [31:0] d;
        logic        e;
        s = 0;
        if (en != 0)
            for (int k = 2; k >= 0; k--)
                if (pick(k))
                    s = k + 1;
        vld = (s != 0) && tbl[tsel[s - 1]].src_ok;
        ev = (vld != 0) ? tbl[tsel[s - 1]].value : 16'h0;
        st = 32'(s) | 32'(vld << 2);
        for (int i = 0; i < 9; i++)
            st[8 + 2 * i +: 2] = 2'(cres(i));
        chk("out_slot", 32'(out_slot), 32'(s));
        chk("out_valid", 32'(out_valid), 32'(vld));
        chk("out_value", 32'(out_value), 32'(ev));
        apb(1'b0, `CTS_STATUS_OFS, 32'h0, d, e);
        chk("status", d, st);
        apb(1'b0, `CTS_OUT_OFS, 32'h0, d, e);
        chk("out_reg", d, 32'(ev));
    endtask : check_all

    // operator only taken when both new argument types are in use
    task automatic set_cond(int i);
        int ty [4] = '{0, 1, 2, 15};
        int o;
        a1t[i] = ty[rnd(4)];
        a1n[i] = rnd(NI);
        a2t[i] = ty[rnd(4)];
        a2n[i] = rnd(NI);
        cv[i] = rnd(4);
        o = rnd(8);
        if (a1t[i] != 0 && a2t[i] != 0)
            op[i] = o;
        wr(`CTS_COND_BASE + 8'(8 * i),
           32'(a1t[i] | a1n[i] << 4 | a2t[i] << 8 | a2n[i] << 12 | o << 16));
        wr(`CTS_COND_BASE + 8'(8 * i + 4), 32'(cv[i]));
    endtask : set_cond

    // ========================================
    // main sequence
    initial
    begin
        logic [31:0] d;
        logic        e;
        int          k;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        apb(1'b0, `CTS_CTRL_OFS, 32'h0, d, e);
        chk("ctrl_rst", d, 32'h0);
        apb(1'b0, `CTS_TBLSEL_OFS, 32'h0, d, e);
        chk("tblsel_rst", d, 32'h654);
        apb(1'b0, `CTS_COMB_OFS, 32'h0, d, e);
        chk("comb_rst", d, 32'h11);
        apb(1'b0, `CTS_COND_BASE, 32'h0, d, e);
        chk("cond_rst", d, 32'h0);
        apb(1'b0, 8'h20, 32'h0, d, e);
        chk("unmapped_err", 32'(e), 32'h1);
        chk("unmapped_data", d, 32'h0);
        check_all();
        repeat (150)
        begin
            en = int'(rnd(8) != 0);
            wr(`CTS_CTRL_OFS, 32'(en));
            for (int s = 0; s < 3; s++)
            begin
                tsel[s] = rnd(16);
                comb[s] = rnd(5);
            end
            wr(`CTS_TBLSEL_OFS, 32'(tsel[0] | tsel[1] << 4 | tsel[2] << 8));
            wr(`CTS_COMB_OFS, 32'(comb[0] | comb[1] << 4 | comb[2] << 8));
            for (int i = 0; i < 9; i++)
                set_cond(i);
            wr(`CTS_OUT_OFS, 32'hFFFFFFFF);
            far.refresh(seed);
            repeat (3) @(posedge mclk);
            check_all();
            k = rnd(9);
            apb(1'b0, `CTS_COND_BASE + 8'(8 * k), 32'h0, d, e);
            chk("cond_cfg", d,
                32'(a1t[k] | a1n[k] << 4 | a2t[k] << 8 | a2n[k] << 12 | op[k] << 16));
            apb(1'b0, `CTS_COMB_OFS, 32'h0, d, e);
            chk("comb", d, 32'(comb[0] | comb[1] << 4 | comb[2] << 8));
            // table and source change alone, configuration untouched
            far.refresh(seed);
            repeat (3) @(posedge mclk);
            check_all();
        end
        print_verdict();
    end

    // about three times the expected run length
    initial
    begin
        #(50ns * 60000);
        num_errors++;
        print_verdict();
    end
endmodule : cts_selector_bench
